// ---- dv/ieacd_bus_model.sv ----
// far-side model: poll responders, acceptor holdoff and byte transmitter
// assumes requests from the bench, synchronous to clk_i
`timescale 1ns/1ps
module ieacd_bus_model #(
  parameter logic [7:0] PPR = 8'h5a,
  parameter int DLY = 3
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // requests
  input wire logic idy_i,
  input wire logic holdoff_i,
  input wire logic send_i,
  // bus side
  output logic [7:0] dio_o,
  output logic anrs_o,
  output logic sent_o
);
  int cnt_q;
  logic send_q;
  // released lines toggle so a stale value never passes
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dio_o <= 8'h00;
    end else begin
      dio_o <= idy_i ? PPR : ~dio_o;
    end
  end
  // slow acceptor: holdoff shows DLY cycles after holdoff_i is first sampled high
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q <= 0;
      anrs_o <= 1'b0;
    end else begin
      cnt_q <= holdoff_i ? cnt_q + 1 : 0;
      anrs_o <= holdoff_i && cnt_q >= DLY;
    end
  end
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      send_q <= 1'b0;
      sent_o <= 1'b0;
    end else begin
      send_q <= send_i;
      sent_o <= send_i && !send_q;
    end
  end
endmodule

// ---- dv/ieacd_chk_sv_pkgless_chk.sv ----
// port checker for the aux command decoder
// assumes it is bound to ieacd_top on one clock domain
`timescale 1ns/1ps
`include "ieacd_regs.svh"
module ieacd_chk (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // bus
  input wire logic [`IEACD_ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic avs_waitrequest_o,
  // messages and states
  input wire logic rtl_o,
  input wire logic gts_o,
  input wire logic tca_o,
  input wire logic tcs_o,
  input wire logic rpp_o,
  input wire logic sic_o,
  input wire logic rsc_o,
  input wire logic lon_o,
  input wire logic listener_active_o,
  input wire logic sys_ctrl_o,
  input wire logic atn_o,
  input wire logic eoi_o,
  input wire logic idy_o,
  input wire logic ifc_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  logic cmt;
  logic [7:0] cmd;
  assign cmt = avs_write_i && !avs_waitrequest_o && avs_address_i == `IEACD_OFS_AUX;
  assign cmd = avs_writedata_i[7:0];
  ////////////////////////////////////////
  sequence s_rtl_pls;
    rtl_o ##1 !rtl_o;
  endsequence
  property p_wait;
    (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o;
  endproperty
  property p_rtl_clr;
    cmt && cmd == 8'h07 |=> s_rtl_pls;
  endproperty
  property p_rtl_set;
    cmt && cmd == 8'h87 |=> rtl_o;
  endproperty
  property p_gts;
    $rose(gts_o) |=> !gts_o;
  endproperty
  property p_tca;
    $rose(tca_o) |=> !tca_o;
  endproperty
  property p_tcs;
    $rose(tcs_o) |=> !tcs_o;
  endproperty
  property p_sic;
    cmt && cmd == 8'h8f |=> sic_o && rsc_o;
  endproperty
  property p_ifc;
    sic_o && rsc_o |=> ifc_o && sys_ctrl_o;
  endproperty
  property p_rpp;
    cmt && cmd == 8'h8e |=> rpp_o;
  endproperty
  property p_idy;
    idy_o |-> atn_o && eoi_o;
  endproperty
  property p_lon;
    lon_o |=> listener_active_o;
  endproperty
  a_wait: assert property (p_wait) else $error("waitrequest late");
  a_rtl_clr: assert property (p_rtl_clr) else $error("rtl pulse wrong");
  a_rtl_set: assert property (p_rtl_set) else $error("rtl not held");
  a_gts: assert property (p_gts) else $error("gts too long");
  a_tca: assert property (p_tca) else $error("tca too long");
  a_tcs: assert property (p_tcs) else $error("tcs too long");
  a_sic: assert property (p_sic) else $error("sic rsc not set");
  a_ifc: assert property (p_ifc) else $error("ifc missing");
  a_rpp: assert property (p_rpp) else $error("rpp not set");
  a_idy: assert property (p_idy) else $error("poll drive wrong");
  a_lon: assert property (p_lon) else $error("listener not active");
endmodule
bind ieacd_top ieacd_chk chk_u (.clk_i, .rst_n_i, .avs_address_i, .avs_read_i, .avs_write_i,
  .avs_writedata_i, .avs_waitrequest_o, .rtl_o, .gts_o, .tca_o, .tcs_o, .rpp_o, .sic_o,
  .rsc_o, .lon_o, .listener_active_o, .sys_ctrl_o, .atn_o, .eoi_o, .idy_o, .ifc_o);

// ---- dv/testbench.sv ----
// self-checking bench for the aux command decoder
// assumes design, checker and bus model compiled before it
`timescale 1ns/1ps
`include "ieacd_regs.svh"
module testbench;
  localparam logic [7:0] PPR = 8'h5a;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [3:0] avs_address_i = 4'h0;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  logic [7:0] dio;
  logic anrs, sent;
  logic holdoff = 1'b0;
  logic send = 1'b0;
  logic rtl_o, gts_o, tca_o, tcs_o, rpp_o, sic_o, rsc_o, lon_o, ton_o;
  logic la_o, ta_o, sc_o, atn_o, eoi_o, idy_o, ifc_o;
  logic [31:0] rd_d;
  int num_errors = 0;
  int n_checks = 0;
  always #5 clk_i = ~clk_i;
  ieacd_top dut_u (.clk_i, .rst_n_i, .avs_address_i, .avs_read_i, .avs_write_i,
    .avs_writedata_i, .avs_readdata_o, .avs_waitrequest_o, .dio_i(dio), .ah_anrs_i(anrs),
    .byte_sent_i(sent), .rtl_o, .gts_o, .tca_o, .tcs_o, .rpp_o, .sic_o, .rsc_o, .lon_o,
    .ton_o, .listener_active_o(la_o), .talker_active_o(ta_o), .sys_ctrl_o(sc_o), .atn_o,
    .eoi_o, .idy_o, .ifc_o);
  ieacd_bus_model #(.PPR(PPR), .DLY(3)) bus_u (.clk_i, .rst_n_i, .idy_i(idy_o),
    .holdoff_i(holdoff), .send_i(send), .dio_o(dio), .anrs_o(anrs), .sent_o(sent));
  ////////////////////////////////////////
  task automatic end_of_test();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chkw(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk(input logic got, input logic exp);
    chkw({31'h0, got}, {31'h0, exp});
  endtask
  // holds the request until waitrequest is sampled low
  task automatic acc(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= wr;
    avs_read_i <= !wr;
    do begin
      @(posedge clk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 50);
    rd_d = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    if (n >= 50) begin
      num_errors++;
      end_of_test();
    end
  endtask
  task automatic aux(input logic [7:0] c);
    acc(1'b1, `IEACD_OFS_AUX, {24'h0, c});
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (100000) @(posedge clk_i);
    num_errors++;
    end_of_test();
  end
  initial begin
    repeat (8) @(posedge clk_i);
    rst_n_i <= 1'b1;
    tick(0);
    chkw({16'h0, rtl_o, gts_o, tca_o, tcs_o, rpp_o, sic_o, rsc_o, lon_o, ton_o, la_o, ta_o,
      sc_o, atn_o, eoi_o, idy_o, ifc_o}, 32'h0);
    acc(1'b0, `IEACD_OFS_AUX, 32'h0);
    chkw(rd_d, 32'h0);
    aux(8'h97);
    tick(0);
    chk(rtl_o, 1'b0);
    aux(8'h07);
    tick(0);
    chk(rtl_o, 1'b1);
    tick(1);
    chk(rtl_o, 1'b0);
    aux(8'h87);
    tick(5);
    chk(rtl_o, 1'b1);
    aux(8'h8e);
    tick(0);
    chk(rpp_o, 1'b1);
    // transceivers are taken as enabled here
    aux(8'h8f);
    tick(0);
    chk(sic_o & rsc_o, 1'b1);
    tick(6);
    // ifc pins the controller in active, so the pending poll starts once ifc ends
    chkw({28'h0, ifc_o, sc_o, atn_o, idy_o}, 32'he);
    tick(10000);
    aux(8'h0f);
    tick(0);
    chkw({30'h0, sic_o, rsc_o}, 32'h0);
    tick(3);
    chk(ifc_o, 1'b0);
    chkw({29'h0, atn_o, eoi_o, idy_o}, 32'h7);
    tick(200);
    acc(1'b0, `IEACD_OFS_COMMAND_PASS_THROUGH_REG, 32'h0);
    chkw(rd_d, {24'h0, PPR});
    aux(8'h0e);
    tick(3);
    chkw({30'h0, rpp_o, idy_o}, 32'h0);
    aux(8'h0b);
    tick(0);
    chk(gts_o, 1'b1);
    tick(3);
    chk(atn_o, 1'b0);
    aux(8'h0c);
    tick(0);
    chk(tca_o, 1'b1);
    tick(3);
    chk(atn_o, 1'b1);
    aux(8'h0b);
    aux(8'h08);
    tick(3);
    chk(eoi_o, 1'b1);
    @(posedge clk_i) send <= 1'b1;
    @(posedge clk_i) send <= 1'b0;
    tick(3);
    chk(eoi_o, 1'b0);
    aux(8'h89);
    tick(3);
    chk(la_o, 1'b1);
    aux(8'h0d);
    tick(0);
    chk(tcs_o, 1'b1);
    tick(3);
    chk(atn_o, 1'b0);
    @(posedge clk_i) holdoff <= 1'b1;
    tick(8);
    chk(atn_o, 1'b1);
    @(posedge clk_i) holdoff <= 1'b0;
    aux(8'h09);
    tick(3);
    chk(la_o, 1'b0);
    aux(8'h8a);
    tick(3);
    chk(ta_o, 1'b1);
    aux(8'h0a);
    tick(3);
    chk(ta_o, 1'b0);
    aux(8'h8a);
    aux(8'h89);
    acc(1'b1, `IEACD_OFS_CTRL, 32'h1);
    tick(3);
    chkw({30'h0, lon_o, ton_o}, 32'h0);
    acc(1'b1, `IEACD_OFS_CTRL, 32'h0);
    aux(8'h87);
    aux(8'h8e);
    aux(8'h8f);
    acc(1'b1, `IEACD_OFS_CTRL, 32'h2);
    tick(1);
    chkw({29'h0, rtl_o, rpp_o, sic_o}, 32'h0);
    end_of_test();
  end
endmodule

// ---- rtl/ieacd_cmd_dec.sv ----
// decodes one auxiliary command byte into a strobe per code 07h..0fh
// assumes a one-cycle write strobe from the bus slave
`timescale 1ns/1ps
`include "ieacd_regs.svh"

module ieacd_cmd_dec (
  // command byte
  input wire logic wr_i,
  input wire logic [7:0] cmd_i,
  // decoded strobes
  output logic [`IEACD_NUM_CODES-1:0] hit_o,
  output logic set_o
);

  logic grp_ok;
  logic [3:0] code;

  assign code = cmd_i[`IEACD_CMD_CODE_HI:`IEACD_CMD_CODE_LO];
  // other groups belong to other decoders and are ignored here
  assign grp_ok = wr_i && (cmd_i[`IEACD_CMD_GRP_HI:`IEACD_CMD_GRP_LO] == `IEACD_CMD_GRP);
  assign set_o = cmd_i[`IEACD_CMD_SET_BIT];

  genvar g;
  generate
    for (g = 0; g < `IEACD_NUM_CODES; g = g + 1) begin : g_hit
      assign hit_o[g] = grp_ok && (code == (`IEACD_CODE_FIRST + 4'(g)));
    end
  endgenerate

endmodule

// ---- rtl/ieacd_pkg.sv ----
// types shared by the auxiliary command decoder files
// assumes nothing of its surroundings
package ieacd_pkg;

  // controller function states
  typedef enum logic [2:0] {
    IEACD_C_IDLE,
    IEACD_C_ACTIVE,
    IEACD_C_STANDBY,
    IEACD_C_TCS_WAIT,
    IEACD_C_PPOLL
  } ieacd_ctrl_st_t;

endpackage

// ---- rtl/ieacd_regs.svh ----
// register offsets, field positions, command codes and reset values of the
// auxiliary command decoder; assumes a 32-bit avalon-mm slave with byte addresses
`ifndef IEACD_REGS_SVH
`define IEACD_REGS_SVH

// byte offsets
`define IEACD_ADDR_W 4
`define IEACD_OFS_AUX 4'h0
`define IEACD_OFS_STAT 4'h4
`define IEACD_OFS_COMMAND_PASS_THROUGH_REG 4'h8
`define IEACD_OFS_CTRL 4'hc

// auxiliary command byte layout
`define IEACD_CMD_SET_BIT 7
`define IEACD_CMD_GRP_HI 6
`define IEACD_CMD_GRP_LO 4
`define IEACD_CMD_CODE_HI 3
`define IEACD_CMD_CODE_LO 0
`define IEACD_CMD_GRP 3'h0
`define IEACD_CODE_FIRST 4'h7
`define IEACD_NUM_CODES 9

// strobe index = code - 7
`define IEACD_I_RTL 0
`define IEACD_I_FEOI 1
`define IEACD_I_LON 2
`define IEACD_I_TON 3
`define IEACD_I_GTS 4
`define IEACD_I_TCA 5
`define IEACD_I_TCS 6
`define IEACD_I_RPP 7
`define IEACD_I_SIC 8

// control register
`define IEACD_CTRL_PON 0
`define IEACD_CTRL_CHRST 1

// status register
`define IEACD_ST_RTL 0
`define IEACD_ST_LON 1
`define IEACD_ST_TON 2
`define IEACD_ST_LACS 3
`define IEACD_ST_TACS 4
`define IEACD_ST_CACS 5
`define IEACD_ST_CSBS 6
`define IEACD_ST_RPP 7
`define IEACD_ST_SIC 8
`define IEACD_ST_RSC 9
`define IEACD_ST_FEOI 10
`define IEACD_ST_IFC 11
`define IEACD_ST_PPOLL 12
`define IEACD_ST_TCS_WAIT 13

// reset values
`define IEACD_RST_DATA 32'h0000_0000
`define IEACD_RST_BYTE 8'h00

`endif

// ---- rtl/ieacd_top.sv ----
// auxiliary command decoder for codes 07h..0fh of an ieee 488 interface
// assumes avalon-mm master on clk_i, bus pins and handshake inputs synchronous
//
// Our own choices: the Avalon-MM slave port and the address map.
`timescale 1ns/1ps
`include "ieacd_regs.svh"

module ieacd_top (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // avalon-mm slave
  input wire logic [`IEACD_ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // bus and handshake status
  input wire logic [7:0] dio_i,
  input wire logic ah_anrs_i,
  input wire logic byte_sent_i,
  // local messages
  output logic rtl_o,
  output logic gts_o,
  output logic tca_o,
  output logic tcs_o,
  output logic rpp_o,
  output logic sic_o,
  output logic rsc_o,
  output logic lon_o,
  output logic ton_o,
  // interface function states
  output logic listener_active_o,
  output logic talker_active_o,
  output logic sys_ctrl_o,
  // bus drive
  output logic atn_o,
  output logic eoi_o,
  output logic idy_o,
  output logic ifc_o
);

  ////////////////////////////////////////////////////////////////////////////
  // bus slave

  logic wait_q;
  logic req;
  logic acc_wr;
  logic aux_wr;
  logic ctrl_wr;
  logic [31:0] rdata_d;
  logic [31:0] rdata_q;
  logic [31:0] status;

  assign req = avs_read_i || avs_write_i;
  // write commits at the edge where waitrequest is seen low
  assign acc_wr = avs_write_i && !wait_q;
  assign aux_wr = acc_wr && (avs_address_i == `IEACD_OFS_AUX);
  assign ctrl_wr = acc_wr && (avs_address_i == `IEACD_OFS_CTRL);

  // one wait cycle per access: low for exactly one cycle after a request
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wait_q <= 1'b1;
    end else begin
      wait_q <= !(req && wait_q);
    end
  end

  logic [7:0] command_pass_through_reg_q;

  always_comb begin
    rdata_d = `IEACD_RST_DATA;
    case (avs_address_i)
      `IEACD_OFS_STAT: rdata_d = status;
      `IEACD_OFS_COMMAND_PASS_THROUGH_REG: rdata_d = {24'h00_0000, command_pass_through_reg_q};
      default: rdata_d = `IEACD_RST_DATA;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_q <= `IEACD_RST_DATA;
    end else if (avs_read_i && wait_q) begin
      rdata_q <= rdata_d;
    end
  end

  assign avs_readdata_o = rdata_q;
  assign avs_waitrequest_o = wait_q;

  ////////////////////////////////////////////////////////////////////////////
  // control register: power-on level and self-clearing chip reset

  logic pon_q;
  logic chrst;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pon_q <= 1'b0;
    end else if (ctrl_wr) begin
      pon_q <= avs_writedata_i[`IEACD_CTRL_PON];
    end
  end

  assign chrst = ctrl_wr && avs_writedata_i[`IEACD_CTRL_CHRST];

  ////////////////////////////////////////////////////////////////////////////
  // command decode

  logic [`IEACD_NUM_CODES-1:0] hit;
  logic set_cmd;
  logic set_hit;
  logic clr_hit;

  ieacd_cmd_dec u_dec (
    .wr_i (aux_wr),
    .cmd_i (avs_writedata_i[7:0]),
    .hit_o (hit),
    .set_o (set_cmd)
  );

  ////////////////////////////////////////////////////////////////////////////
  // return to local

  logic rtl_hold_q;
  logic rtl_q;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rtl_hold_q <= 1'b0;
      rtl_q <= 1'b0;
    end else if (chrst) begin
      rtl_hold_q <= 1'b0;
      rtl_q <= 1'b0;
    end else begin
      if (hit[`IEACD_I_RTL]) begin
        rtl_hold_q <= set_cmd;
      end
      // clear code still shows one true cycle, then drops
      rtl_q <= hit[`IEACD_I_RTL] || rtl_hold_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pulsed controller messages, one cycle each

  logic gts_q;
  logic tca_q;
  logic tcs_q;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      gts_q <= 1'b0;
      tca_q <= 1'b0;
      tcs_q <= 1'b0;
    end else begin
      gts_q <= hit[`IEACD_I_GTS];
      tca_q <= hit[`IEACD_I_TCA];
      tcs_q <= hit[`IEACD_I_TCS];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // send eoi with next byte

  logic feoi_q;

  // a new request in the same cycle as a byte leaves wins, so it is not lost
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      feoi_q <= 1'b0;
    end else if (hit[`IEACD_I_FEOI]) begin
      feoi_q <= 1'b1;
    end else if (byte_sent_i) begin
      feoi_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // listen only, talk only

  logic lon_q;
  logic ton_q;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lon_q <= 1'b0;
      ton_q <= 1'b0;
    end else if (pon_q) begin
      lon_q <= 1'b0;
      ton_q <= 1'b0;
    end else begin
      if (hit[`IEACD_I_LON]) begin
        lon_q <= set_cmd;
      end
      if (hit[`IEACD_I_TON]) begin
        ton_q <= set_cmd;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // parallel poll request, interface clear, system control

  logic rpp_q;
  logic sic_q;
  logic rsc_q;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rpp_q <= 1'b0;
    end else if (chrst) begin
      rpp_q <= 1'b0;
    end else if (hit[`IEACD_I_RPP]) begin
      rpp_q <= set_cmd;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sic_q <= 1'b0;
      rsc_q <= 1'b0;
    end else begin
      if (chrst) begin
        sic_q <= 1'b0;
      end else if (hit[`IEACD_I_SIC]) begin
        sic_q <= set_cmd;
      end
      // rsc survives chip reset; only 0f drops it
      if (hit[`IEACD_I_SIC]) begin
        rsc_q <= set_cmd;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // controller function

  ieacd_pkg::ieacd_ctrl_st_t cst_q;
  logic ifc_d;
  logic lacs_q;
  logic tacs_q;

  // sic and rsc together drive ifc; the host times the 100 us itself
  assign ifc_d = sic_q && rsc_q;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lacs_q <= 1'b0;
      tacs_q <= 1'b0;
    end else begin
      lacs_q <= lon_q;
      tacs_q <= ton_q;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cst_q <= ieacd_pkg::IEACD_C_IDLE;
    end else if (ifc_d) begin
      // system controller sending ifc takes charge of the bus
      cst_q <= ieacd_pkg::IEACD_C_ACTIVE;
    end else begin
      case (cst_q)
        ieacd_pkg::IEACD_C_ACTIVE: begin
          if (gts_q) begin
            cst_q <= ieacd_pkg::IEACD_C_STANDBY;
          end else if (rpp_q) begin
            cst_q <= ieacd_pkg::IEACD_C_PPOLL;
          end
        end
        ieacd_pkg::IEACD_C_STANDBY: begin
          if (tca_q) begin
            cst_q <= ieacd_pkg::IEACD_C_ACTIVE;
          end else if (tcs_q && lacs_q) begin
            cst_q <= ieacd_pkg::IEACD_C_TCS_WAIT;
          end
        end
        ieacd_pkg::IEACD_C_TCS_WAIT: begin
          // tca still overrides a pending synchronous take
          if (tca_q || ah_anrs_i) begin
            cst_q <= ieacd_pkg::IEACD_C_ACTIVE;
          end
        end
        ieacd_pkg::IEACD_C_PPOLL: begin
          if (!rpp_q) begin
            cst_q <= ieacd_pkg::IEACD_C_ACTIVE;
          end
        end
        default: cst_q <= cst_q;
      endcase
    end
  end

  // poll answer is sampled every polling cycle; last value stays readable
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      command_pass_through_reg_q <= `IEACD_RST_BYTE;
    end else if (cst_q == ieacd_pkg::IEACD_C_PPOLL) begin
      command_pass_through_reg_q <= dio_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registered pin drive

  logic active;
  logic polling;
  logic atn_q;
  logic eoi_q;
  logic idy_q;
  logic ifc_q;
  logic sysc_q;

  assign active = (cst_q == ieacd_pkg::IEACD_C_ACTIVE);
  assign polling = (cst_q == ieacd_pkg::IEACD_C_PPOLL);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      atn_q <= 1'b0;
      eoi_q <= 1'b0;
      idy_q <= 1'b0;
      ifc_q <= 1'b0;
      sysc_q <= 1'b0;
    end else begin
      atn_q <= active || polling;
      idy_q <= polling;
      // idy is eoi under atn; otherwise eoi marks the flagged byte
      eoi_q <= polling || (feoi_q && !atn_q);
      ifc_q <= ifc_d;
      sysc_q <= rsc_q && sic_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status and outputs

  always_comb begin
    status = `IEACD_RST_DATA;
    status[`IEACD_ST_RTL] = rtl_q;
    status[`IEACD_ST_LON] = lon_q;
    status[`IEACD_ST_TON] = ton_q;
    status[`IEACD_ST_LACS] = lacs_q;
    status[`IEACD_ST_TACS] = tacs_q;
    status[`IEACD_ST_CACS] = active;
    status[`IEACD_ST_CSBS] = (cst_q == ieacd_pkg::IEACD_C_STANDBY);
    status[`IEACD_ST_RPP] = rpp_q;
    status[`IEACD_ST_SIC] = sic_q;
    status[`IEACD_ST_RSC] = rsc_q;
    status[`IEACD_ST_FEOI] = feoi_q;
    status[`IEACD_ST_IFC] = ifc_q;
    status[`IEACD_ST_PPOLL] = polling;
    status[`IEACD_ST_TCS_WAIT] = (cst_q == ieacd_pkg::IEACD_C_TCS_WAIT);
  end

  assign rtl_o = rtl_q;
  assign gts_o = gts_q;
  assign tca_o = tca_q;
  assign tcs_o = tcs_q;
  assign rpp_o = rpp_q;
  assign sic_o = sic_q;
  assign rsc_o = rsc_q;
  assign lon_o = lon_q;
  assign ton_o = ton_q;
  assign listener_active_o = lacs_q;
  assign talker_active_o = tacs_q;
  assign sys_ctrl_o = sysc_q;
  assign atn_o = atn_q;
  assign eoi_o = eoi_q;
  assign idy_o = idy_q;
  assign ifc_o = ifc_q;

endmodule
